/* hdl/rig_gate.v */
// Remote input gate: accepts remote commands, drives remote status outputs.
// Assumes one 20 MHz clock, AXI4-Lite master on the same clock, async pin inputs.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`include "rig_defines.vh"
`default_nettype none
module rig_gate #(
   parameter NBITS = 16
) (
   // Clock and reset
   input  wire              clk_in,
   input  wire              resetn_in,
   // Remote pins
   input  wire [NBITS-1:0]  remote_pins_in,
   input  wire              heartbeat_in,
   output reg  [7:0]        remote_status_out,
   output reg               heartbeat_out,
   // Local requests from other control sources
   input  wire              local_start_in,
   input  wire              local_stop_in,
   // Function triggers
   output reg               start_pulse_out,
   output reg  [2:0]        main_select_out,
   output reg               stop_pulse_out,
   output reg               pause_pulse_out,
   output reg               continue_pulse_out,
   output reg               reset_pulse_out,
   // Machine state
   input  wire              running_in,
   input  wire              paused_in,
   // Interrupt
   output wire              irq_out,
   // AXI4-Lite
   input  wire [7:0]        s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output wire              s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output wire              s_axi_wready,
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [7:0]        s_axi_araddr,
   input  wire              s_axi_arvalid,
   output wire              s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready
);
////////////////////////////////////////////////////////////////////////////////
// Registers
reg  [31:0]       ctrl;
reg  [NBITS-1:0]  virt_in;
reg  [31:0]       imap0;
reg  [31:0]       imap1;
reg  [31:0]       omap0;
reg  [31:0]       omap1;
reg  [7:0]        irq_stat;
reg  [7:0]        irq_en;
reg               error_flag;
reg  [NBITS-1:0]  sync1;
reg  [NBITS-1:0]  sync2;
reg               hb1;
reg               hb2;
reg  [7:0]        func_q;
wire [63:0]       imap = {imap1, imap0};
wire [63:0]       omap = {omap1, omap0};
////////////////////////////////////////////////////////////////////////////////
// Input synchronisers and source select
always @(posedge clk_in or negedge resetn_in) begin
   if (!resetn_in) begin
      sync1 <= {NBITS{1'b0}};
      sync2 <= {NBITS{1'b0}};
      hb1   <= 1'b0;
      hb2   <= 1'b0;
   end else begin
      sync1 <= remote_pins_in;
      sync2 <= sync1;
      hb1   <= heartbeat_in;
      hb2   <= hb1;
   end
end
wire [NBITS-1:0] in_word = ctrl[`RIG_CTRL_VIRT] ? virt_in : sync2;
reg  [7:0] func_lvl;
integer i;
always @* begin
   func_lvl = 8'h00;
   for (i = 0; i < 8; i = i + 1) begin
      if (imap[i*8+`RIG_MAP_VALID])
         func_lvl[i] = in_word[imap[i*8 +: 4]];
   end
end
////////////////////////////////////////////////////////////////////////////////
// Acceptance and triggering
wire teach      = ctrl[`RIG_CTRL_TEACH];
wire ready      = ctrl[`RIG_CTRL_READY];
wire estop      = ctrl[`RIG_CTRL_ESTOP];
wire guard      = ctrl[`RIG_CTRL_GUARD];
wire remote_ok  = ctrl[`RIG_CTRL_REMOTE] & ~teach;
wire [7:0] rise = func_lvl & ~func_q;
wire ok_start   = remote_ok & ~error_flag & ready & ~estop & ~guard
                  & ~func_lvl[`RIG_F_PAUSE] & ~func_lvl[`RIG_F_STOP];
wire ok_gen     = remote_ok & ~error_flag;
wire ok_pause   = ok_gen & running_in;
wire ok_cont    = ok_gen & paused_in & ~func_lvl[`RIG_F_PAUSE] & ~func_lvl[`RIG_F_STOP];
wire ok_reset   = remote_ok & ready;
wire trig_start = rise[`RIG_F_START] & ok_start;
wire trig_stop  = rise[`RIG_F_STOP] & ok_gen;
wire trig_pause = rise[`RIG_F_PAUSE] & ok_pause;
wire trig_cont  = rise[`RIG_F_CONT] & ok_cont;
wire trig_reset = rise[`RIG_F_RESET] & ok_reset;
wire lstart     = local_start_in & ~ctrl[`RIG_CTRL_REMOTE] & ~error_flag & ready;
wire lstop      = local_stop_in & ~ctrl[`RIG_CTRL_REMOTE];
wire err_set    = ctrl[`RIG_CTRL_ERRSET];
always @(posedge clk_in or negedge resetn_in) begin
   if (!resetn_in) begin
      func_q             <= 8'h00;
      start_pulse_out    <= 1'b0;
      main_select_out    <= 3'h0;
      stop_pulse_out     <= 1'b0;
      pause_pulse_out    <= 1'b0;
      continue_pulse_out <= 1'b0;
      reset_pulse_out    <= 1'b0;
      error_flag         <= 1'b0;
      heartbeat_out      <= 1'b0;
   end else begin
      func_q             <= func_lvl;
      start_pulse_out    <= trig_start | lstart;
      if (trig_start)
         main_select_out <= {func_lvl[`RIG_F_SEL4], func_lvl[`RIG_F_SEL2], func_lvl[`RIG_F_SEL1]};
      else if (lstart)
         main_select_out <= 3'h0;
      stop_pulse_out     <= trig_stop | lstop;
      pause_pulse_out    <= trig_pause;
      continue_pulse_out <= trig_cont;
      reset_pulse_out    <= trig_reset;
      if (err_set)
         error_flag <= 1'b1;
      else if (trig_reset)
         error_flag <= 1'b0;
      heartbeat_out      <= hb2;
   end
end
////////////////////////////////////////////////////////////////////////////////
// Status outputs, mapped; keep running in teach mode
wire [7:0] stat_src = {running_in, paused_in, ctrl[`RIG_CTRL_HOME], teach, ctrl[`RIG_CTRL_DRIVE],
                       error_flag, ready, remote_ok};
reg  [7:0] next_status;
integer k;
always @* begin
   next_status = 8'h00;
   for (k = 0; k < 8; k = k + 1) begin
      if (omap[k*8+`RIG_MAP_VALID] && omap[k*8 +: 4] < 4'h8)
         next_status[omap[k*8 +: 3]] = stat_src[k];
   end
end
always @(posedge clk_in or negedge resetn_in) begin
   if (!resetn_in)
      remote_status_out <= 8'h00;
   else
      remote_status_out <= next_status;
end
////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave
reg        aw_hold;
reg        w_hold;
reg  [7:0] aw_addr;
reg [31:0] w_data;
reg  [3:0] w_strb;
assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
assign s_axi_wready  = ~w_hold & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;
wire [7:0]  wa   = aw_hold ? aw_addr : s_axi_awaddr;
wire [31:0] wd   = w_hold ? w_data : s_axi_wdata;
wire [3:0]  ws   = w_hold ? w_strb : s_axi_wstrb;
wire have_aw     = aw_hold | (s_axi_awvalid & s_axi_awready);
wire have_w      = w_hold | (s_axi_wvalid & s_axi_wready);
wire do_wr       = have_aw & have_w;
wire [31:0] bmask = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
wire wr_ok = (wa == `RIG_CTRL_ADDR) | (wa == `RIG_VIRT_ADDR) | (wa == `RIG_IMAP0_ADDR) |
             (wa == `RIG_IMAP1_ADDR) | (wa == `RIG_OMAP0_ADDR) | (wa == `RIG_OMAP1_ADDR) |
             (wa == `RIG_IRQ_EN_ADDR) | (wa == `RIG_IRQ_CLR_ADDR) | (wa == `RIG_VBIT_ADDR);
wire [7:0] irq_ev = {2'h0, trig_reset, trig_cont, trig_pause, trig_stop, trig_start, err_set};
wire [7:0] irq_clr = (do_wr && wa == `RIG_IRQ_CLR_ADDR) ? (wd[7:0] & bmask[7:0]) : 8'h00;
assign irq_out = |(irq_stat & irq_en);
always @(posedge clk_in or negedge resetn_in) begin
   if (!resetn_in) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RIG_RESP_OKAY;
      ctrl         <= `RIG_CTRL_RESET;
      virt_in      <= {NBITS{1'b0}};
      imap0        <= `RIG_MAP_RESET0;
      imap1        <= `RIG_MAP_RESET1;
      omap0        <= `RIG_MAP_RESET0;
      omap1        <= `RIG_MAP_RESET1;
      irq_stat     <= 8'h00;
      irq_en       <= 8'h00;
   end else begin
      ctrl[`RIG_CTRL_ERRSET] <= 1'b0;
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      if (s_axi_awvalid && s_axi_awready && !do_wr) begin
         aw_hold <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready && !do_wr) begin
         w_hold <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
         s_axi_bvalid <= 1'b0;
      if (do_wr) begin
         aw_hold      <= 1'b0;
         w_hold       <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_ok ? `RIG_RESP_OKAY : `RIG_RESP_SLVERR;
         case (wa)
            `RIG_CTRL_ADDR:   ctrl  <= (ctrl & ~bmask) | (wd & bmask);
            `RIG_VIRT_ADDR:   virt_in <= (virt_in & ~bmask[NBITS-1:0]) | (wd[NBITS-1:0] & bmask[NBITS-1:0]);
            `RIG_VBIT_ADDR:   if (ws[0]) virt_in[wd[3:0]] <= wd[`RIG_VBIT_VAL];
            `RIG_IMAP0_ADDR:  imap0 <= (imap0 & ~bmask) | (wd & bmask);
            `RIG_IMAP1_ADDR:  imap1 <= (imap1 & ~bmask) | (wd & bmask);
            `RIG_OMAP0_ADDR:  omap0 <= (omap0 & ~bmask) | (wd & bmask);
            `RIG_OMAP1_ADDR:  omap1 <= (omap1 & ~bmask) | (wd & bmask);
            `RIG_IRQ_EN_ADDR: if (ws[0]) irq_en <= wd[7:0];
            default: begin
            end
         endcase
      end
   end
end
always @(posedge clk_in or negedge resetn_in) begin
   if (!resetn_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `RIG_RESP_OKAY;
   end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `RIG_RESP_OKAY;
      case (s_axi_araddr)
         `RIG_CTRL_ADDR:     s_axi_rdata <= ctrl;
         `RIG_STATUS_ADDR:   s_axi_rdata <= {15'h0000, error_flag, func_lvl, remote_status_out};
         `RIG_VIRT_ADDR:     s_axi_rdata <= {{(32-NBITS){1'b0}}, virt_in};
         `RIG_IMAP0_ADDR:    s_axi_rdata <= imap0;
         `RIG_IMAP1_ADDR:    s_axi_rdata <= imap1;
         `RIG_OMAP0_ADDR:    s_axi_rdata <= omap0;
         `RIG_OMAP1_ADDR:    s_axi_rdata <= omap1;
         `RIG_IRQ_STAT_ADDR: s_axi_rdata <= {24'h000000, irq_stat};
         `RIG_IRQ_EN_ADDR:   s_axi_rdata <= {24'h000000, irq_en};
         `RIG_IRQ_CLR_ADDR:  s_axi_rdata <= 32'h0000_0000;
         `RIG_VBIT_ADDR:     s_axi_rdata <= 32'h0000_0000;
         default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RIG_RESP_SLVERR;
         end
      endcase
   end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
   end
end
endmodule
`default_nettype wire

/* common/rig_defines.vh */
// Constants for the remote input gate: register map, fields, reset values.
// Assumes inclusion by the gate's design file and by the self-checking bench.
`ifndef RIG_DEFINES_VH
`define RIG_DEFINES_VH
// Register byte addresses
`define RIG_CTRL_ADDR     8'h00
`define RIG_STATUS_ADDR   8'h04
`define RIG_VIRT_ADDR     8'h08
`define RIG_IMAP0_ADDR    8'h0c
`define RIG_IMAP1_ADDR    8'h10
`define RIG_OMAP0_ADDR    8'h14
`define RIG_OMAP1_ADDR    8'h18
`define RIG_IRQ_STAT_ADDR 8'h1c
`define RIG_IRQ_EN_ADDR   8'h20
`define RIG_IRQ_CLR_ADDR  8'h24
`define RIG_VBIT_ADDR     8'h28
`define RIG_ADDR_W        8
// Control fields
`define RIG_CTRL_REMOTE   0
`define RIG_CTRL_VIRT     1
`define RIG_CTRL_TEACH    2
`define RIG_CTRL_READY    3
`define RIG_CTRL_ESTOP    4
`define RIG_CTRL_GUARD    5
`define RIG_CTRL_DRIVE    6
`define RIG_CTRL_ERRSET   7
`define RIG_CTRL_HOME     8
`define RIG_CTRL_RESET    32'h0000_0008
// Function indices (input side)
`define RIG_F_START       3'h0
`define RIG_F_SEL1        3'h1
`define RIG_F_SEL2        3'h2
`define RIG_F_SEL4        3'h3
`define RIG_F_STOP        3'h4
`define RIG_F_PAUSE       3'h5
`define RIG_F_CONT        3'h6
`define RIG_F_RESET       3'h7
// Default mapping: function n on bit n, valid bit 7 set per byte
`define RIG_MAP_RESET0    32'h8382_8180
`define RIG_MAP_RESET1    32'h8786_8584
`define RIG_MAP_VALID     7
// Virtual port fields
`define RIG_VBIT_VAL      4
// Bus answers
`define RIG_RESP_OKAY     2'h0
`define RIG_RESP_SLVERR   2'h2
`endif

/* tb/rig_gate_monitor.sv */
// Port checker for the remote input gate.
// Assumes one clock domain; bound to every rig_gate instance.
`default_nettype none
module rig_gate_monitor (
   // Clock and reset
   input wire logic       clk_in,
   input wire logic       resetn_in,
   // Observed ports
   input wire logic       heartbeat_in,
   input wire logic [7:0] remote_status_out,
   input wire logic       heartbeat_out,
   input wire logic       start_pulse_out,
   input wire logic [2:0] main_select_out,
   input wire logic       stop_pulse_out,
   input wire logic       pause_pulse_out,
   input wire logic       continue_pulse_out,
   input wire logic       reset_pulse_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);
   ////////////////////////////////////////////////////////////////////////////
   avail_teach_a: assert property (remote_status_out[4] |-> !remote_status_out[0])
      else $error("available while teaching");
   heart_copy_a: assert property (heartbeat_out == $past(heartbeat_in, 3))
      else $error("heartbeat copy wrong");
   start_once_a: assert property (start_pulse_out |=> !start_pulse_out)
      else $error("start pulse too long");
   start_cond_a: assert property (start_pulse_out |-> remote_status_out[1] && !remote_status_out[2])
      else $error("start outside acceptance");
   sel_hold_a: assert property ($changed(main_select_out) |-> start_pulse_out)
      else $error("select changed without start");
   pause_cond_a: assert property (pause_pulse_out |-> remote_status_out[7])
      else $error("pause while not running");
   cont_cond_a: assert property (continue_pulse_out |-> remote_status_out[6])
      else $error("continue while not paused");
   reset_cond_a: assert property (reset_pulse_out |-> remote_status_out[1] && remote_status_out[0])
      else $error("reset outside acceptance");
   stop_cond_a: assert property (stop_pulse_out && remote_status_out[0] |-> !remote_status_out[2])
      else $error("remote stop during error");
   err_clear_a: assert property ($fell(remote_status_out[2]) |-> reset_pulse_out || $past(reset_pulse_out)
      || $past(reset_pulse_out, 2))
      else $error("error cleared without reset");
   cover property (start_pulse_out && main_select_out == 3'h5);
   cover property (reset_pulse_out);
   cover property (continue_pulse_out);
endmodule
bind rig_gate rig_gate_monitor i_rig_gate_monitor (.clk_in(clk_in), .resetn_in(resetn_in),
   .heartbeat_in(heartbeat_in), .remote_status_out(remote_status_out), .heartbeat_out(heartbeat_out),
   .start_pulse_out(start_pulse_out), .main_select_out(main_select_out), .stop_pulse_out(stop_pulse_out),
   .pause_pulse_out(pause_pulse_out), .continue_pulse_out(continue_pulse_out),
   .reset_pulse_out(reset_pulse_out));
`default_nettype wire

/* tb/rig_host.sv */
// Host model: remote pins and heartbeat of a controlling logic unit.
// Assumes the bench calls set_bits; pins idle low.
`default_nettype none
module rig_host (
   // Clock and status
   input  wire logic        clk_in,
   input  wire logic [7:0]  status_in,
   // Pins
   output var  logic [15:0] pins_out,
   output var  logic        heartbeat_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      pins_out = 16'h0000;
      heartbeat_out = 1'b0;
   end
   always begin
      repeat (9) @(posedge clk_in);
      heartbeat_out <= ~heartbeat_out;
   end
   task automatic set_bits(input logic [15:0] v);
      while (status_in[0] !== 1'b1 && status_in[1] !== 1'b1)
         @(posedge clk_in);
      @(posedge clk_in);
      pins_out <= v;
      repeat (8) @(posedge clk_in);
   endtask
endmodule
`default_nettype wire

/* tb/rig_gate_tb.sv */
// Self-checking bench for the remote input gate.
// Assumes rig_host and the checker are compiled first.
`include "rig_defines.vh"
`default_nettype none
module rig_gate_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic        local_start_in = 1'b0;
   logic        local_stop_in = 1'b0;
   logic [3:0]  wstrb = 4'hf;
   logic        running_in = 1'b0;
   logic        paused_in = 1'b0;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        awvalid = 1'b0;
   logic        wvalid = 1'b0;
   logic        bready = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready = 1'b0;
   logic [31:0] rd_v;
   logic [1:0]  rd_r;
   wire logic   awready, wready, bvalid, arready, rvalid, irq, hb_in, hb_out;
   wire logic   p_start, p_stop, p_pause, p_cont, p_rst;
   wire logic [1:0]  bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [15:0] pins;
   wire logic [7:0]  status;
   wire logic [2:0]  sel;
   wire logic [4:0]  pv;
   int          errors = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          cnt [5];
   assign pv = {p_rst, p_cont, p_pause, p_stop, p_start};
   always #25 clk_in = ~clk_in;
   rig_host i_rig_host (.clk_in(clk_in), .status_in(status), .pins_out(pins), .heartbeat_out(hb_in));
   rig_gate i_rig_gate (.clk_in(clk_in), .resetn_in(resetn_in), .remote_pins_in(pins),
      .heartbeat_in(hb_in), .remote_status_out(status), .heartbeat_out(hb_out),
      .local_start_in(local_start_in), .local_stop_in(local_stop_in), .start_pulse_out(p_start),
      .main_select_out(sel), .stop_pulse_out(p_stop), .pause_pulse_out(p_pause),
      .continue_pulse_out(p_cont), .reset_pulse_out(p_rst), .running_in(running_in),
      .paused_in(paused_in), .irq_out(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   ////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      for (int i = 0; i < 5; i++)
         if (pv[i] === 1'b1) cnt[i] <= cnt[i] + 1;
      if (cyc == 6000) begin
         errors = errors + 1;
         results();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk_in);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk_in);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      rd_r = rresp;
      chk(rdata, e);
   endtask
   task automatic press(input logic [15:0] v);
      i_rig_host.set_bits(v);
      i_rig_host.set_bits(16'h0000);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk_in);
      resetn_in <= 1'b1;
      rdchk(`RIG_CTRL_ADDR, `RIG_CTRL_RESET);
      rdchk(`RIG_IMAP0_ADDR, `RIG_MAP_RESET0);
      rdchk(`RIG_IMAP1_ADDR, `RIG_MAP_RESET1);
      rdchk(`RIG_OMAP0_ADDR, `RIG_MAP_RESET0);
      rdchk(8'h2c, 32'h0);
      chk(rd_r, `RIG_RESP_SLVERR);
      chk(status, 8'h02);
      press(16'h0001);
      chk(cnt[0], 0);
      $display("reset and local source test done");
      wr(`RIG_IRQ_EN_ADDR, 32'h1);
      wr(`RIG_CTRL_ADDR, 32'h9);
      chk(status, 8'h03);
      local_start_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      local_start_in <= 1'b0;
      running_in <= 1'b1;
      paused_in <= 1'b1;
      press(16'h000b);
      chk(cnt[0], 1);
      chk(sel, 3'h5);
      for (int i = 4; i < 8; i++) begin
         press(16'h0001 << i);
         chk(cnt[i - 3], 1);
      end
      $display("remote command test done");
      wr(`RIG_CTRL_ADDR, 32'hd);
      chk(status, 8'hd2);
      running_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      chk(status, 8'h52);
      press(16'h0081);
      chk(cnt[0] + cnt[4], 2);
      i_rig_host.set_bits(16'h0001);
      wr(`RIG_CTRL_ADDR, 32'h9);
      i_rig_host.set_bits(16'h0000);
      chk(cnt[0], 1);
      $display("teach test done");
      wr(`RIG_CTRL_ADDR, 32'h89);
      chk(status[2], 1'b1);
      chk(irq, 1'b1);
      wr(`RIG_IRQ_EN_ADDR, 32'h0);
      chk(irq, 1'b0);
      wr(`RIG_IRQ_EN_ADDR, 32'h1);
      chk(irq, 1'b1);
      rdchk(`RIG_IRQ_STAT_ADDR, 32'h3f);
      press(16'h0011);
      chk(cnt[0] + cnt[1], 2);
      press(16'h0080);
      chk(cnt[4], 2);
      chk(status[2], 1'b0);
      wr(`RIG_IRQ_CLR_ADDR, 32'h3f);
      chk(irq, 1'b0);
      $display("error and interrupt test done");
      wr(`RIG_CTRL_ADDR, 32'hb);
      wr(`RIG_VIRT_ADDR, 32'hb);
      wr(`RIG_VIRT_ADDR, 32'h0);
      chk(cnt[0], 2);
      chk(sel, 3'h5);
      wr(`RIG_VBIT_ADDR, 32'h14);
      wr(`RIG_VBIT_ADDR, 32'h04);
      chk(cnt[1], 2);
      wstrb <= 4'h1;
      wr(`RIG_VIRT_ADDR, 32'hff00);
      wstrb <= 4'hf;
      rdchk(`RIG_VIRT_ADDR, 32'h0);
      $display("virtual input test done");
      wr(`RIG_CTRL_ADDR, 32'h8);
      local_start_in <= 1'b1;
      @(posedge clk_in);
      local_start_in <= 1'b0;
      local_stop_in <= 1'b1;
      @(posedge clk_in);
      local_stop_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      chk(cnt[0], 3);
      chk(cnt[1], 3);
      chk(sel, 3'h0);
      $display("local source test done");
      results();
   end
endmodule
`default_nettype wire
